// ---- design/eeprom_cmd_pkg.sv ----
package eeprom_cmd_pkg;

	// System clock rate and derived cycles per microsecond.
	localparam int CLK_HZ = 20_000_000;
	localparam int CYCLES_PER_US = CLK_HZ / 1_000_000;

	// Longest self-timed cycle times, in microseconds.
	localparam int WORD8_TIME_US = 1_000;
	localparam int WORD16_TIME_US = 2_000;
	localparam int BULK_TIME_US = 15_000;

	// Longest times round down to whole clock cycles.
	localparam int WORD8_CYCLES = WORD8_TIME_US * CYCLES_PER_US;
	localparam int WORD16_CYCLES = WORD16_TIME_US * CYCLES_PER_US;
	localparam int BULK_CYCLES = BULK_TIME_US * CYCLES_PER_US;
	localparam int TIMER_W = 19;

	// Field widths.
	localparam int OPCODE_W = 4;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	localparam int COUNT_W = 5;

	// Address and data lengths per organisation.
	localparam logic [COUNT_W-1:0] ADDR_BITS_WIDE = 5'h06;
	localparam logic [COUNT_W-1:0] ADDR_BITS_NARROW = 5'h07;
	localparam logic [COUNT_W-1:0] DATA_BITS_WIDE = 5'h10;
	localparam logic [COUNT_W-1:0] DATA_BITS_NARROW = 5'h08;
	localparam logic [COUNT_W-1:0] OPCODE_LAST = 5'h03;

	// Opcodes; read is 10xx and write is x1xx.
	localparam logic [1:0] OP_READ_TOP = 2'h2;
	localparam int OP_WRITE_BIT = 2;
	localparam logic [OPCODE_W-1:0] OP_PROGRAM_UNLOCK = 4'h3;
	localparam logic [OPCODE_W-1:0] OP_PROGRAM_LOCK = 4'h0;
	localparam logic [OPCODE_W-1:0] OP_ERASE_EVERYTHING = 4'h2;
	localparam logic [OPCODE_W-1:0] OP_FILL_EVERYTHING = 4'h1;

	// Kind of self-timed cycle presented to the cell array.
	typedef enum logic [1:0] {
		PROG_NONE = 2'b00,
		PROG_WORD = 2'b01,
		PROG_ERASE_ALL = 2'b10,
		PROG_FILL_ALL = 2'b11
	} prog_kind_e;

endpackage

// ---- design/level_sync.sv ----
`timescale 1ns/100ps

// Two-stage synchroniser for level signals entering a clock domain.
module level_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge clk_i) begin
		stage1_reg <= async_i;
		sync_o <= stage1_reg;
	end

endmodule // level_sync

// ---- design/serial_eeprom_command_engine.sv ----
`timescale 1ns/100ps

// Summary of operation
// - No operation runs while the supply detector reports low supply.
// - Programming starts locked; write, erase and fill need an unlock first.
// - Organisation high: 6 address bits, 16-bit words, 27 or 11 clocks.
// - Organisation low: 7 address bits, 8-bit words, 20 or 12 clocks.
// - Four opcode bits follow the start bit; address arrives MSB first.
// - First rising edge with select and data in high is the start bit.
// - Before a start bit all pin activity is ignored.
// - Only fully clocked-in instructions execute; truncated ones do nothing.
// - After the last bit, clock and data are ignored until reselect.
// - A read issued while no self-timed cycle runs drives one zero bit after the last address edge.
// - Read data changes after rising clock edges.
// - Read data leaves MSB first down to bit zero.
// - Output floats at next edge after bit zero or at deselect.
// - A complete enabled write starts a self-timed erase-then-program cycle.
// - Word cycle lasts at most 1 ms narrow, 2 ms wide.
// - Enabled erase-everything sets all bits to one within 15 ms.
// - Fill-everything programs every word within 15 ms, without erase.
// - Deselect resets the serial logic; a running cycle still completes.
// - Ready flag is low throughout every self-timed cycle.
// - Bits are sampled and launched on rising serial clock edges.
module serial_eeprom_command_engine
#(
	parameter int WORD8_CYCLES_P = eeprom_cmd_pkg::WORD8_CYCLES,
	parameter int WORD16_CYCLES_P = eeprom_cmd_pkg::WORD16_CYCLES,
	parameter int BULK_CYCLES_P = eeprom_cmd_pkg::BULK_CYCLES
) (
	// System clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Serial link.
	input wire logic serial_clk_i,
	input wire logic chip_select_i,
	input wire logic serial_in_i,
	output logic serial_out_o,
	output logic serial_out_oe_o,
	// Configuration and supply status.
	input wire logic array_width_select_i,
	input wire logic supply_ok_i,
	// Ready flag, high when no self-timed cycle runs.
	output logic program_cycle_flag_o,
	// Cell array read port, serial clock domain.
	output logic [eeprom_cmd_pkg::ADDR_W-1:0] array_rd_addr_o,
	input wire logic [eeprom_cmd_pkg::DATA_W-1:0] array_rd_data_i,
	// Cell array programming port, system clock domain.
	output eeprom_cmd_pkg::prog_kind_e prog_kind_o,
	output logic [eeprom_cmd_pkg::ADDR_W-1:0] prog_addr_o,
	output logic [eeprom_cmd_pkg::DATA_W-1:0] prog_data_o,
	output logic prog_commit_o
);

	import eeprom_cmd_pkg::*;

	typedef enum logic [2:0] {
		L_WAIT = 3'b000,
		L_OPCODE = 3'b001,
		L_ADDR = 3'b010,
		L_WDATA = 3'b011,
		L_RDATA = 3'b100,
		L_DONE = 3'b101
	} link_state_e;

	typedef enum logic [0:0] {
		C_READY = 1'b0,
		C_BUSY = 1'b1
	} core_state_e;

	link_state_e link_state_reg;
	logic [COUNT_W-1:0] bit_cnt_reg;
	logic [OPCODE_W-1:0] opcode_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [DATA_W-1:0] data_reg;
	logic [DATA_W-1:0] out_shift_reg;
	logic [2:0] link_sync;
	logic link_wide;
	logic link_supply_ok;
	logic link_ready;
	logic [COUNT_W-1:0] addr_len;
	logic [COUNT_W-1:0] data_len;
	logic [ADDR_W-1:0] addr_next;
	logic [DATA_W-1:0] data_next;
	logic is_read;
	logic needs_data;
	logic issue_now;
	logic req_toggle_reg;
	logic [OPCODE_W-1:0] cmd_opcode_reg;
	logic [ADDR_W-1:0] cmd_addr_reg;
	logic [DATA_W-1:0] cmd_data_reg;
	logic cmd_wide_reg;

	level_sync #(
		.WIDTH(3)
	) link_sync_u (
		.clk_i(serial_clk_i),
		.async_i({array_width_select_i, supply_ok_i, program_cycle_flag_o}),
		.sync_o(link_sync)
	);

	assign {link_wide, link_supply_ok, link_ready} = link_sync;

	assign addr_len = link_wide ? ADDR_BITS_WIDE : ADDR_BITS_NARROW;
	assign data_len = link_wide ? DATA_BITS_WIDE : DATA_BITS_NARROW;
	assign addr_next = {addr_reg[ADDR_W-2:0], serial_in_i};
	assign data_next = {data_reg[DATA_W-2:0], serial_in_i};
	assign is_read = (opcode_reg[3:2] == OP_READ_TOP);
	assign needs_data = opcode_reg[OP_WRITE_BIT]
		|| (opcode_reg == OP_FILL_EVERYTHING);

	// A command is handed over only once its last bit is in.
	always_comb begin
		issue_now = 1'b0;
		if (link_state_reg == L_ADDR && bit_cnt_reg == addr_len - 5'h01
			&& !is_read && !needs_data) begin
			issue_now = 1'b1;
		end
		if (link_state_reg == L_WDATA
			&& bit_cnt_reg == data_len - 5'h01) begin
			issue_now = 1'b1;
		end
	end

	// Frame sequencer; deselect clears it and floats the output at once.
	always_ff @(posedge serial_clk_i or negedge chip_select_i) begin
		if (!chip_select_i) begin
			link_state_reg <= L_WAIT;
			bit_cnt_reg <= 5'h00;
			opcode_reg <= 4'h0;
			addr_reg <= 7'h00;
			data_reg <= 16'h0000;
			out_shift_reg <= 16'h0000;
			serial_out_o <= 1'b0;
			serial_out_oe_o <= 1'b0;
			array_rd_addr_o <= 7'h00;
		end else begin
			case (link_state_reg)
				L_WAIT: begin
					if (serial_in_i) begin
						link_state_reg <= L_OPCODE;
						bit_cnt_reg <= 5'h00;
					end
				end
				L_OPCODE: begin
					opcode_reg <= {opcode_reg[2:0], serial_in_i};
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					if (bit_cnt_reg == OPCODE_LAST) begin
						link_state_reg <= L_ADDR;
						bit_cnt_reg <= 5'h00;
					end
				end
				L_ADDR: begin
					addr_reg <= addr_next;
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					if (bit_cnt_reg == addr_len - 5'h01) begin
						bit_cnt_reg <= 5'h00;
						if (is_read) begin
							if (link_supply_ok && link_ready) begin
								array_rd_addr_o <= addr_next;
								serial_out_o <= 1'b0;
								serial_out_oe_o <= 1'b1;
								link_state_reg <= L_RDATA;
							end else begin
								link_state_reg <= L_DONE;
							end
						end else if (needs_data) begin
							link_state_reg <= L_WDATA;
						end else begin
							link_state_reg <= L_DONE;
						end
					end
				end
				L_WDATA: begin
					data_reg <= data_next;
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					if (bit_cnt_reg == data_len - 5'h01) begin
						link_state_reg <= L_DONE;
					end
				end
				L_RDATA: begin
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					if (bit_cnt_reg == 5'h00) begin
						if (link_wide) begin
							serial_out_o <= array_rd_data_i[15];
							out_shift_reg <= {array_rd_data_i[14:0], 1'b0};
						end else begin
							serial_out_o <= array_rd_data_i[7];
							out_shift_reg <= {array_rd_data_i[6:0], 9'h000};
						end
					end else if (bit_cnt_reg == data_len) begin
						serial_out_oe_o <= 1'b0;
						link_state_reg <= L_DONE;
					end else begin
						serial_out_o <= out_shift_reg[15];
						out_shift_reg <= {out_shift_reg[14:0], 1'b0};
					end
				end
				L_DONE: link_state_reg <= L_DONE;
				default: link_state_reg <= L_WAIT;
			endcase
		end
	end

	// Command hold registers and request toggle; they survive deselect.
	always_ff @(posedge serial_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req_toggle_reg <= 1'b0;
			cmd_opcode_reg <= 4'h0;
			cmd_addr_reg <= 7'h00;
			cmd_data_reg <= 16'h0000;
			cmd_wide_reg <= 1'b0;
		end else if (issue_now) begin
			req_toggle_reg <= ~req_toggle_reg;
			cmd_opcode_reg <= opcode_reg;
			cmd_wide_reg <= link_wide;
			if (link_state_reg == L_WDATA) begin
				cmd_data_reg <= data_next;
				cmd_addr_reg <= addr_reg;
			end else begin
				cmd_data_reg <= data_reg;
				cmd_addr_reg <= addr_next;
			end
		end
	end

	core_state_e core_state_reg;
	logic [1:0] core_sync;
	logic req_seen_reg;
	logic req_event;
	logic core_supply_ok;
	logic unlocked_reg;
	logic [TIMER_W-1:0] timer_reg;
	logic start_cycle;
	prog_kind_e start_kind;
	logic [TIMER_W-1:0] start_count;

	level_sync #(
		.WIDTH(2)
	) core_sync_u (
		.clk_i(clk_i),
		.async_i({req_toggle_reg, supply_ok_i}),
		.sync_o(core_sync)
	);

	assign core_supply_ok = core_sync[0];
	assign req_event = core_sync[1] ^ req_seen_reg;

	always_ff @(posedge clk_i) begin
		req_seen_reg <= reset_n_i && core_sync[1];
	end

	// Decode of a received command into a self-timed cycle.
	always_comb begin
		start_cycle = 1'b0;
		start_kind = PROG_NONE;
		start_count = TIMER_W'(WORD8_CYCLES_P - 1);
		if (req_event && core_supply_ok && unlocked_reg
			&& core_state_reg == C_READY) begin
			if (cmd_opcode_reg[OP_WRITE_BIT]) begin
				start_cycle = 1'b1;
				start_kind = PROG_WORD;
				start_count = cmd_wide_reg
					? TIMER_W'(WORD16_CYCLES_P - 1)
					: TIMER_W'(WORD8_CYCLES_P - 1);
			end else if (cmd_opcode_reg == OP_ERASE_EVERYTHING) begin
				start_cycle = 1'b1;
				start_kind = PROG_ERASE_ALL;
				start_count = TIMER_W'(BULK_CYCLES_P - 1);
			end else if (cmd_opcode_reg == OP_FILL_EVERYTHING) begin
				start_cycle = 1'b1;
				start_kind = PROG_FILL_ALL;
				start_count = TIMER_W'(BULK_CYCLES_P - 1);
			end
		end
	end

	// Programming lock; low supply relocks as at power-up.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i || !core_supply_ok) begin
			unlocked_reg <= 1'b0;
		end else if (req_event && core_state_reg == C_READY) begin
			if (cmd_opcode_reg == OP_PROGRAM_UNLOCK) begin
				unlocked_reg <= 1'b1;
			end else if (cmd_opcode_reg == OP_PROGRAM_LOCK) begin
				unlocked_reg <= 1'b0;
			end
		end
	end

	// Self-timed cycle, counted on the free-running system clock.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			core_state_reg <= C_READY;
			timer_reg <= '0;
			program_cycle_flag_o <= 1'b1;
			prog_kind_o <= PROG_NONE;
			prog_addr_o <= 7'h00;
			prog_data_o <= 16'h0000;
			prog_commit_o <= 1'b0;
		end else begin
			prog_commit_o <= 1'b0;
			case (core_state_reg)
				C_READY: begin
					if (start_cycle) begin
						core_state_reg <= C_BUSY;
						timer_reg <= start_count;
						program_cycle_flag_o <= 1'b0;
						prog_kind_o <= start_kind;
						prog_addr_o <= cmd_addr_reg;
						prog_data_o <= cmd_data_reg;
					end
				end
				C_BUSY: begin
					timer_reg <= timer_reg - TIMER_W'(1);
					if (!core_supply_ok) begin
						core_state_reg <= C_READY;
						program_cycle_flag_o <= 1'b1;
					end else if (timer_reg == '0) begin
						core_state_reg <= C_READY;
						program_cycle_flag_o <= 1'b1;
						prog_commit_o <= 1'b1;
					end
				end
				default: begin
					core_state_reg <= C_READY;
				end
			endcase
		end
	end

endmodule // serial_eeprom_command_engine

// ---- tb/host_model.sv ----
`timescale 1ns/100ps
module host_model (
	output logic serial_clk_o,
	output logic cs_o,
	output logic sdi_o,
	input wire logic sdo_i,
	input wire logic oe_i
);
	logic [31:0] seen;
	logic [31:0] oe_seen;
	initial begin
		serial_clk_o = 1'b0;
		cs_o = 1'b1;
		sdi_o = 1'b0;
		// A deselect edge clears the frame logic before the first frame.
		#8 cs_o = 1'b0;
	end
	// Sends n bits MSB first, then extra edges with a wandering data line.
	// The clock idles low outside frames; slow stretches the low phase.
	task automatic frame(input logic [31:0] bits, input int n, extra, slow);
		int i;
		cs_o = 1'b1;
		for (i = 0; i < n + extra; i++) begin
			// While the device drives, the host leaves the line to it.
			sdi_o = (i < n) ? bits[n-1-i] : (oe_i ? sdo_i : ~sdi_o);
			#16 serial_clk_o = 1'b1;
			#16 serial_clk_o = 1'b0;
			// A released output reads as the inverse of its last bit.
			seen = {seen[30:0], oe_i ? sdo_i : ~sdo_i};
			oe_seen = {oe_seen[30:0], oe_i};
			#(16 * slow - 16);
		end
		cs_o = 1'b0;
		#24 sdi_o = ~sdi_o;
		#24;
	endtask
endmodule // host_model

// ---- tb/eeprom_checker.sv ----
`timescale 1ns/100ps
module eeprom_checker
	import eeprom_cmd_pkg::*;
#(
	parameter int WORD8_CYCLES_P = 20,
	parameter int WORD16_CYCLES_P = 40,
	parameter int BULK_CYCLES_P = 100
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic serial_clk_i,
	input wire logic chip_select_i,
	input wire logic serial_in_i,
	input wire logic serial_out_o,
	input wire logic serial_out_oe_o,
	input wire logic array_width_select_i,
	input wire logic supply_ok_i,
	input wire logic program_cycle_flag_o,
	input wire logic [ADDR_W-1:0] array_rd_addr_o,
	input wire logic [DATA_W-1:0] array_rd_data_i,
	input prog_kind_e prog_kind_o,
	input wire logic [ADDR_W-1:0] prog_addr_o,
	input wire logic [DATA_W-1:0] prog_data_o,
	input wire logic prog_commit_o
);
	int low_cnt;
	always_ff @(posedge clk_i) begin
		if (!reset_n_i || program_cycle_flag_o)
			low_cnt <= 0;
		else
			low_cnt <= low_cnt + 1;
	end
	property p_commit_ends_cycle;
		@(posedge clk_i) disable iff (!reset_n_i) prog_commit_o |->
		program_cycle_flag_o && !$past(program_cycle_flag_o)
		##1 !prog_commit_o;
	endproperty
	a_commit_ends_cycle: assert property (p_commit_ends_cycle)
		else $error("commit not at end of busy period");
	property p_word_time;
		@(posedge clk_i) disable iff (!reset_n_i)
		prog_commit_o && prog_kind_o == PROG_WORD |->
		low_cnt == WORD8_CYCLES_P || low_cnt == WORD16_CYCLES_P;
	endproperty
	a_word_time: assert property (p_word_time)
		else $error("word cycle length wrong");
	property p_bulk_time;
		@(posedge clk_i) disable iff (!reset_n_i)
		prog_commit_o && prog_kind_o != PROG_WORD |-> low_cnt == BULK_CYCLES_P;
	endproperty
	a_bulk_time: assert property (p_bulk_time)
		else $error("bulk cycle length wrong");
	property p_busy_has_kind;
		@(posedge clk_i) disable iff (!reset_n_i)
		$fell(program_cycle_flag_o) |-> prog_kind_o != PROG_NONE;
	endproperty
	a_busy_has_kind: assert property (p_busy_has_kind)
		else $error("busy without a cycle kind");
	property p_busy_holds;
		@(posedge clk_i) disable iff (!reset_n_i)
		!program_cycle_flag_o && !$past(program_cycle_flag_o) |->
		$stable(prog_kind_o) && $stable(prog_addr_o) && $stable(prog_data_o);
	endproperty
	a_busy_holds: assert property (p_busy_holds)
		else $error("cycle operands moved while busy");
	property p_supply_blocks;
		@(posedge clk_i) disable iff (!reset_n_i)
		!supply_ok_i [*5] |-> program_cycle_flag_o && !prog_commit_o;
	endproperty
	a_supply_blocks: assert property (p_supply_blocks)
		else $error("cycle runs with supply low");
	property p_deselect_floats;
		@(posedge clk_i) disable iff (!reset_n_i)
		!chip_select_i |-> !serial_out_oe_o;
	endproperty
	a_deselect_floats: assert property (p_deselect_floats)
		else $error("output driven while deselected");
	property p_dummy_zero;
		@(posedge serial_clk_i) disable iff (!chip_select_i)
		$rose(serial_out_oe_o) |-> !serial_out_o;
	endproperty
	a_dummy_zero: assert property (p_dummy_zero)
		else $error("first read bit not zero");
	property p_read_span;
		@(posedge serial_clk_i) disable iff (!chip_select_i)
		$rose(serial_out_oe_o) |-> serial_out_oe_o [*8];
	endproperty
	a_read_span: assert property (p_read_span)
		else $error("read output cut short");
endmodule // eeprom_checker
bind serial_eeprom_command_engine eeprom_checker #(
	.WORD8_CYCLES_P(WORD8_CYCLES_P),
	.WORD16_CYCLES_P(WORD16_CYCLES_P),
	.BULK_CYCLES_P(BULK_CYCLES_P)
) u_checker (.clk_i, .reset_n_i, .serial_clk_i, .chip_select_i,
	.serial_in_i, .serial_out_o, .serial_out_oe_o, .array_width_select_i,
	.supply_ok_i, .program_cycle_flag_o, .array_rd_addr_o, .array_rd_data_i,
	.prog_kind_o, .prog_addr_o, .prog_data_o, .prog_commit_o);

// ---- tb/serial_eeprom_command_engine_tb.sv ----
`timescale 1ns/100ps
module serial_eeprom_command_engine_tb;
	import eeprom_cmd_pkg::*;
	localparam int W8 = 20;
	localparam int W16 = 40;
	localparam int BULK = 100;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic supply = 1'b1;
	logic array_width_select = 1'b1;
	logic sclk, cs, sdi, sdo, oe, flag, commit;
	logic [6:0] rd_addr, p_addr;
	logic [15:0] p_data;
	prog_kind_e kind;
	int mismatches = 0;
	int samples_checked = 0;
	int t;
	int low_len = 0;
	// The cell array answers with a pattern built from the address.
	wire [15:0] rd_data = {rd_addr, 2'h1, ~rd_addr};
	host_model host (.serial_clk_o(sclk), .cs_o(cs), .sdi_o(sdi),
		.sdo_i(sdo), .oe_i(oe));
	serial_eeprom_command_engine #(.WORD8_CYCLES_P(W8),
		.WORD16_CYCLES_P(W16), .BULK_CYCLES_P(BULK)) dut (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .serial_clk_i(sclk),
		.chip_select_i(cs), .serial_in_i(sdi), .serial_out_o(sdo),
		.serial_out_oe_o(oe), .array_width_select_i(array_width_select),
		.supply_ok_i(supply), .program_cycle_flag_o(flag),
		.array_rd_addr_o(rd_addr), .array_rd_data_i(rd_data),
		.prog_kind_o(kind), .prog_addr_o(p_addr), .prog_data_o(p_data),
		.prog_commit_o(commit));
	initial forever #25 clk_i = ~clk_i;
	// Counts falling edges at which the ready flag has stood low.
	always @(negedge clk_i)
		low_len <= (flag === 1'b0) ? low_len + 1 : 0;
	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wait_flag(input logic v, input int bound);
		t = 0;
		while (flag !== v) begin
			@(negedge clk_i);
			t++;
			if (t > bound) begin
				check("flag wait", v, flag);
				complete_run;
			end
		end
	endtask
	// Times one self-timed cycle in system clocks and checks its kind.
	task automatic cycle(input prog_kind_e k, input int n);
		@(negedge clk_i);
		wait_flag(1'b0, 20);
		wait_flag(1'b1, 400);
		check("busy cycles", n, low_len);
		check("commit", 1'b1, commit);
		check("kind", k, kind);
	endtask
	task automatic refused;
		repeat (20) @(negedge clk_i);
		check("ready", 1'b1, flag);
	endtask
	task automatic t_wide;
		host.frame({1'b1, 4'b1100, 6'h2a, 16'ha5c3}, 27, 0, 1);
		refused();
		host.frame({1'b1, 4'b0011, 6'h00}, 11, 0, 1);
		host.frame({2'b00, 1'b1, 4'b0100, 6'h2a, 16'ha5c3}, 29, 3, 1);
		cycle(PROG_WORD, W16);
		check("addr", 7'h2a, p_addr);
		check("data", 16'ha5c3, p_data);
		host.frame({1'b1, 4'b0100, 6'h2a, 9'h14b}, 20, 0, 1);
		refused();
		host.frame({1'b1, 4'b1000, 6'h15}, 11, 17, 3);
		check("read bits", {1'b0, 7'h15, 2'h1, 7'h6a}, host.seen[17:1]);
		check("read enable", 18'h3fffe, host.oe_seen[17:0]);
		$display("test wide_mode done");
	endtask
	task automatic t_narrow;
		@(negedge clk_i) array_width_select = 1'b0;
		host.frame({1'b1, 4'b0010, 7'h00}, 12, 0, 1);
		cycle(PROG_ERASE_ALL, BULK);
		host.frame({1'b1, 4'b0001, 7'h00, 8'h3c}, 20, 0, 1);
		cycle(PROG_FILL_ALL, BULK);
		check("fill data", 8'h3c, p_data[7:0]);
		host.frame({1'b1, 4'b0111, 7'h5b, 8'h96}, 20, 0, 1);
		cycle(PROG_WORD, W8);
		check("addr", 7'h5b, p_addr);
		check("data", 8'h96, p_data[7:0]);
		host.frame({1'b1, 4'b1000, 7'h5b}, 12, 9, 1);
		check("read bits", {1'b0, 8'ha4}, host.seen[9:1]);
		check("read enable", 10'h3fe, host.oe_seen[9:0]);
		host.frame({1'b1, 4'b0000, 7'h00}, 12, 0, 1);
		host.frame({1'b1, 4'b0100, 7'h11, 8'h22}, 20, 0, 1);
		refused();
		$display("test narrow_mode done");
	endtask
	task automatic t_supply;
		host.frame({1'b1, 4'b0011, 7'h00}, 12, 0, 1);
		host.frame({1'b1, 4'b0100, 7'h33, 8'h44}, 20, 0, 1);
		@(negedge clk_i);
		wait_flag(1'b0, 20);
		supply = 1'b0;
		repeat (8) @(negedge clk_i);
		check("ready", 1'b1, flag);
		supply = 1'b1;
		repeat (5) @(negedge clk_i);
		host.frame({1'b1, 4'b0100, 7'h33, 8'h44}, 20, 0, 1);
		refused();
		$display("test supply_drop done");
	endtask
	initial begin
		repeat (5) @(negedge clk_i);
		reset_n_i = 1'b1;
		repeat (3) @(negedge clk_i);
		t_wide();
		t_narrow();
		t_supply();
		complete_run();
	end
endmodule // serial_eeprom_command_engine_tb
